// [dv/board_model.sv]
`timescale 1ns/1ps
module board_model (
	input wire logic [7:0] i_motor_out,
	input wire logic [7:0] i_motor_oe,
	input wire logic [7:0] i_motor_lvl,
	output logic [7:0] o_motor_pin,
	input wire logic i_line6_out,
	input wire logic i_line6_oe,
	input wire logic [1:0] i_timer_lvl,
	output logic [1:0] o_timer_pin,
	input wire logic i_int_low,
	output logic o_ext_int_pin,
	input wire logic i_rst_low,
	input wire logic i_rst_out,
	input wire logic i_rst_oe,
	output logic o_reset_pin
);
	// ------------------------------------------------------------
	// pin resolution
	// ------------------------------------------------------------
	assign o_motor_pin = (i_motor_oe & i_motor_out) | (~i_motor_oe & i_motor_lvl);
	assign o_timer_pin = {i_timer_lvl[1], i_line6_oe ? i_line6_out : i_timer_lvl[0]};
	assign o_ext_int_pin = !i_int_low;
	// pull-up; board switch or the device pulls it down
	assign o_reset_pin = !(i_rst_low || (i_rst_oe && !i_rst_out));
endmodule

// [dv/port_pins_sva.sv]
`timescale 1ns/1ps
module port_pins_sva (
	input wire logic i_clock,
	input wire logic i_rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic [7:0] i_pulse_alt_en,
	input wire logic [7:0] i_pulse_alt_out,
	input wire logic [7:0] o_motor_out,
	input wire logic [7:0] o_motor_oe,
	input wire logic [3:0] o_serial_oe,
	input wire logic i_serial_rx_en,
	input wire logic [7:0] o_analog_oe,
	input wire logic [7:0] i_analog_en,
	input wire logic [1:0] i_timer_pin,
	input wire logic o_timer_port_line6_oe,
	input wire logic o_capture_input_two,
	input wire logic i_instr_done,
	input wire logic o_ext_int_service,
	input wire logic i_reset_pin,
	input wire logic i_internal_reset_req,
	input wire logic o_reset_pin_out,
	input wire logic o_reset_pin_oe
);
	// ------------------------------------------------------------
	// cycles since the reset pin was last low
	// ------------------------------------------------------------
	// state resets late after a pin reset; hold checks off
	logic [3:0] quiet_q;
	always_ff @(posedge i_clock) begin
		if (!i_rst_b || !i_reset_pin) begin
			quiet_q <= 4'h0;
		end else if (quiet_q != 4'hf) begin
			quiet_q <= quiet_q + 4'h1;
		end
	end
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_rst_b);
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	property p_dirs_in;
		$rose(i_rst_b) |-> !(|{o_motor_oe, o_serial_oe, o_analog_oe, o_timer_port_line6_oe});
	endproperty
	a_dirs_in: assert property (p_dirs_in) else $error("port not input");
	property p_line7;
		disable iff (!i_rst_b || quiet_q != 4'hf)
			$stable(i_timer_pin[1])[*8] |-> o_capture_input_two == i_timer_pin[1];
	endproperty
	a_line7: assert property (p_line7) else $error("line seven lost");
	property p_service;
		o_ext_int_service |-> $past(i_instr_done);
	endproperty
	a_service: assert property (p_service) else $error("early service");
	property p_rst_req;
		$rose(i_internal_reset_req) |-> ##[1:4] o_reset_pin_oe;
	endproperty
	a_rst_req: assert property (p_rst_req) else $error("reset not driven");
	property p_rst_hold;
		$rose(o_reset_pin_oe) |-> o_reset_pin_oe[*4] ##1 !o_reset_pin_oe;
	endproperty
	a_rst_hold: assert property (p_rst_hold) else $error("drive length");
	property p_rst_low;
		o_reset_pin_oe |-> !o_reset_pin_out;
	endproperty
	a_rst_low: assert property (p_rst_low) else $error("reset pin driven high");
	property p_alt;
		disable iff (!i_rst_b || quiet_q != 4'hf) (|i_pulse_alt_en) |=>
			((o_motor_oe & $past(i_pulse_alt_en)) == $past(i_pulse_alt_en))
			&& (((o_motor_out ^ $past(i_pulse_alt_out)) & $past(i_pulse_alt_en)) == 8'h00);
	endproperty
	a_alt: assert property (p_alt) else $error("pulse not on line");
	property p_analog_rel;
		(|i_analog_en) |=> (o_analog_oe & $past(i_analog_en)) == 8'h00;
	endproperty
	a_analog_rel: assert property (p_analog_rel) else $error("analog line still driven");
	property p_rx_rel;
		i_serial_rx_en |=> !o_serial_oe[1];
	endproperty
	a_rx_rel: assert property (p_rx_rel) else $error("receive line still driven");
	property p_apb_ready;
		disable iff (!i_rst_b || quiet_q != 4'hf) psel && !penable |=> pready;
	endproperty
	a_apb_ready: assert property (p_apb_ready) else $error("ready late");
endmodule
bind port_pins_top port_pins_sva u_port_pins_sva (.*);

// [dv/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
	logic i_clock, i_rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
	logic [7:0] paddr = 8'h00, i_motor_pin, o_motor_out, o_motor_oe, i_analog_pin, o_analog_out;
	logic [7:0] i_pulse_alt_en = 8'h00, i_pulse_alt_out = 8'h00, i_analog_en = 8'h00, o_analog_oe;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0] i_serial_pin, o_serial_out, o_serial_oe, serial_lvl = 4'h2;
	logic [1:0] i_timer_pin, timer_lvl = 2'h2;
	logic i_serial_tx_en = 1'b0, i_serial_tx = 1'b0, i_serial_rx_en = 1'b0, i_compare_output = 1'b0;
	logic i_instr_done = 1'b0, i_internal_reset_req = 1'b0, int_low = 1'b0, rst_low = 1'b0;
	logic o_serial_rx_pin, o_timer_port_line6_out, o_timer_port_line6_oe, o_capture_input_one;
	logic o_capture_input_two, i_ext_int_pin, o_ext_int_service, o_irq, i_reset_pin;
	logic o_reset_pin_out, o_reset_pin_oe;
	int miscompares = 0, checks_done = 0;
	localparam logic [7:0] MD = port_pins_pkg::OFF_MOTOR_DIR, XC = port_pins_pkg::OFF_EXT_INT_CTRL,
		TC = port_pins_pkg::OFF_TIMER_CTRL, TD = port_pins_pkg::OFF_TIMER_DATA,
		MA = port_pins_pkg::OFF_MOTOR_DATA, IM = port_pins_pkg::OFF_INT_MASK,
		IS = port_pins_pkg::OFF_INT_STATUS, SD = port_pins_pkg::OFF_SERIAL_DIR,
		AD = port_pins_pkg::OFF_ANALOG_DIR;
	assign i_serial_pin = (o_serial_oe & o_serial_out) | (~o_serial_oe & serial_lvl);
	assign i_analog_pin = (o_analog_oe & o_analog_out) | (~o_analog_oe & 8'hc3);
	port_pins_top u_port_pins_top (.*);
	board_model u_board_model (
		.i_motor_out(o_motor_out),
		.i_motor_oe(o_motor_oe),
		.i_motor_lvl(8'h3c),
		.o_motor_pin(i_motor_pin),
		.i_line6_out(o_timer_port_line6_out),
		.i_line6_oe(o_timer_port_line6_oe),
		.i_timer_lvl(timer_lvl),
		.o_timer_pin(i_timer_pin),
		.i_int_low(int_low),
		.o_ext_int_pin(i_ext_int_pin),
		.i_rst_low(rst_low),
		.i_rst_out(o_reset_pin_out),
		.i_rst_oe(o_reset_pin_oe),
		.o_reset_pin(i_reset_pin)
	);
	initial begin
		i_clock = 1'b0;
		forever #10 i_clock = ~i_clock;
	end
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task wt(input int n);
		repeat (n) @(posedge i_clock);
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge i_clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge i_clock);
		penable <= 1'b1;
		do begin
			@(posedge i_clock);
			n++;
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk("wait", 32'h1, n);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(nm, exp, rd);
	endtask
	task st(input logic [31:0] exp);
		apb(1'b0, IS, 32'h0);
		chk("ext_status", exp, rd & 32'h1);
	endtask
	task drive_len;
		int k;
		for (k = 0; k < 10 && o_reset_pin_oe !== 1'b1; k++) @(posedge i_clock);
		for (k = 0; k < 20 && o_reset_pin_oe === 1'b1; k++) @(posedge i_clock);
		chk("drive_len", 32'h4, k);
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task t_reset;
		chk("motor_oe", 32'h0, o_motor_oe);
		chk("serial_oe", 32'h0, o_serial_oe);
		chk("analog_oe", 32'h0, o_analog_oe);
		rchk("motor_dir", MD, 32'h0);
		rchk("serial_dir", SD, 32'h0);
		rchk("analog_dir", AD, 32'h0);
		rchk("timer_ctrl", TC, 32'h0);
		rchk("unmapped", 8'h3c, 32'h0);
		chk("slverr", 32'h1, {31'h0, err});
	endtask
	task t_ports;
		wr(MD, 32'hff);
		wr(MA, 32'ha5);
		wt(2);
		chk("motor_out", 32'ha5, o_motor_out & o_motor_oe);
		wr(MD, 32'h0f);
		wt(8);
		rchk("motor_data", MA, 32'h35);
		i_pulse_alt_en <= 8'h80;
		i_pulse_alt_out <= 8'h80;
		wt(3);
		chk("motor_alt", 32'h85, o_motor_out & o_motor_oe);
		i_pulse_alt_en <= 8'h00;
		i_serial_tx_en <= 1'b1;
		i_serial_tx <= 1'b1;
		i_serial_rx_en <= 1'b1;
		i_analog_en <= 8'h0f;
		wr(SD, 32'hf);
		wr(port_pins_pkg::OFF_SERIAL_DATA, 32'ha);
		wr(AD, 32'hff);
		wr(port_pins_pkg::OFF_ANALOG_DATA, 32'h5a);
		wt(8);
		chk("serial_oe", 32'hd, o_serial_oe);
		chk("serial_out", 32'h9, o_serial_out & o_serial_oe);
		chk("serial_rx", 32'h1, o_serial_rx_pin);
		chk("analog_out", 32'h50, o_analog_out & o_analog_oe);
	endtask
	task t_timer;
		wr(port_pins_pkg::OFF_TIMER_DIR, 32'h1);
		wr(TD, 32'h3);
		wt(8);
		chk("line6", 32'h3, {o_timer_port_line6_oe, o_timer_port_line6_out});
		chk("cap1", 32'h1, o_capture_input_one);
		rchk("timer_data", TD, 32'h3);
		timer_lvl <= 2'h0;
		wt(8);
		rchk("timer_data", TD, 32'h1);
		wr(TC, 32'h2);
		wt(2);
		chk("line6_cmp", 32'h2, {o_timer_port_line6_oe, o_timer_port_line6_out});
		wr(TC, 32'h1);
		wt(2);
		chk("line6_cap", 32'h0, o_timer_port_line6_oe);
		wr(TC, 32'h0);
		wt(2);
		chk("line6_gpio", 32'h1, o_timer_port_line6_oe);
	endtask
	task t_ext;
		wr(IM, 32'h1);
		wr(XC, 32'h0);
		st(32'h0);
		int_low <= 1'b1;
		wt(10);
		chk("irq", 32'h1, o_irq);
		st(32'h1);
		st(32'h0);
		chk("irq", 32'h0, o_irq);
		wr(XC, 32'h1);
		wt(3);
		st(32'h1);
		st(32'h1);
		int_low <= 1'b0;
		wt(10);
		apb(1'b0, IS, 32'h0);
		wr(XC, 32'h2);
		st(32'h0);
		int_low <= 1'b1;
		wt(10);
		st(32'h0);
		int_low <= 1'b0;
		wt(10);
		st(32'h1);
		wr(IM, 32'h0);
		int_low <= 1'b1;
		wt(4);
		int_low <= 1'b0;
		wt(10);
		chk("irq_masked", 32'h0, o_irq);
		st(32'h1);
		chk("service", 32'h0, o_ext_int_service);
		i_instr_done <= 1'b1;
		wt(3);
		chk("service", 32'h1, o_ext_int_service);
		wr(XC, 32'h12);
		wt(3);
		chk("service", 32'h0, o_ext_int_service);
		rchk("ext_ctrl", XC, 32'h2);
	endtask
	task t_pin_reset;
		wr(port_pins_pkg::OFF_RESET_CTRL, 32'h1);
		drive_len;
		wt(15);
		rchk("motor_dir", MD, 32'h0);
		wr(MD, 32'hff);
		rst_low <= 1'b1;
		wt(6);
		rst_low <= 1'b0;
		wt(15);
		rchk("motor_dir", MD, 32'h0);
		i_internal_reset_req <= 1'b1;
		wt(1);
		i_internal_reset_req <= 1'b0;
		drive_len;
		wt(15);
	endtask
	initial begin
		wt(4);
		i_rst_b <= 1'b1;
		t_reset;
		t_ports;
		t_timer;
		t_ext;
		t_pin_reset;
		wrap_up;
	end
	initial begin
		wt(5000);
		miscompares++;
		wrap_up;
	end
endmodule

// [logic/pin_sync.sv]
`timescale 1ns/1ps
module pin_sync #(
	parameter int unsigned W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic i_clock,
	input wire logic i_rst_b,
	input wire logic [W-1:0] i_pin,
	output logic [W-1:0] o_level
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] level;
	} sync_s;

	sync_s st_q;
	sync_s st_d;

	// ------------------------------------------------------------
	// three stages; a change counts once stages two and three agree
	// ------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		st_d.s1 = i_pin;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		for (int k = 0; k < W; k++) begin
			if (st_q.s2[k] == st_q.s3[k]) begin
				st_d.level[k] = st_q.s3[k];
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			st_q <= {INIT, INIT, INIT, INIT};
		end else begin
			st_q <= st_d;
		end
	end

	assign o_level = st_q.level;

endmodule

// [logic/port_pins_pkg.sv]
package port_pins_pkg;

	// ------------------------------------------------------------
	// widths
	// ------------------------------------------------------------
	localparam int unsigned DATA_W = 32;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned MOTOR_W = 8;
	localparam int unsigned SERIAL_W = 4;
	localparam int unsigned ANALOG_W = 8;
	localparam int unsigned TIMER_W = 2;
	localparam int unsigned INT_W = 2;
	localparam int unsigned SYNC_W = MOTOR_W + SERIAL_W + ANALOG_W + TIMER_W + 2;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_MOTOR_DATA = 8'h00;
	localparam logic [7:0] OFF_MOTOR_DIR = 8'h04;
	localparam logic [7:0] OFF_SERIAL_DATA = 8'h08;
	localparam logic [7:0] OFF_SERIAL_DIR = 8'h0c;
	localparam logic [7:0] OFF_ANALOG_DATA = 8'h10;
	localparam logic [7:0] OFF_ANALOG_DIR = 8'h14;
	localparam logic [7:0] OFF_TIMER_DATA = 8'h18;
	localparam logic [7:0] OFF_TIMER_DIR = 8'h1c;
	localparam logic [7:0] OFF_TIMER_CTRL = 8'h20;
	localparam logic [7:0] OFF_EXT_INT_CTRL = 8'h24;
	localparam logic [7:0] OFF_INT_STATUS = 8'h28;
	localparam logic [7:0] OFF_INT_MASK = 8'h2c;
	localparam logic [7:0] OFF_RESET_CTRL = 8'h30;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int unsigned SERIAL_TX_BIT = 0;
	localparam int unsigned SERIAL_RX_BIT = 1;
	localparam int unsigned TLINE6_BIT = 0;
	localparam int unsigned TLINE7_BIT = 1;
	localparam int unsigned TCR_CAP1_IE_BIT = 0;
	localparam int unsigned TCR_CC_SEL_BIT = 1;
	localparam int unsigned EXT_INT_STATUS_CONTROL_REG_SENS_BIT = 0;
	localparam int unsigned EXT_INT_STATUS_CONTROL_REG_EDGE_BIT = 1;
	localparam int unsigned EXT_INT_STATUS_CONTROL_REG_MASK_BIT = 2;
	localparam int unsigned EXT_INT_STATUS_CONTROL_REG_REQ_BIT = 3;
	localparam int unsigned EXT_INT_STATUS_CONTROL_REG_ACK_BIT = 4;
	localparam int unsigned INT_EXT_BIT = 0;
	localparam int unsigned INT_LINE7_BIT = 1;
	localparam int unsigned RST_SW_BIT = 0;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] DIR_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [31:0] ZERO_WORD = 32'h00000000;
	localparam logic [SYNC_W-1:0] SYNC_INIT = {SYNC_W{1'b1}};

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 20;
	localparam int unsigned RESET_DRIVE_NS = 80;
	localparam int unsigned RESET_DRIVE_CYCLES =
		(RESET_DRIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned RESET_CNT_W = 4;

endpackage

// [logic/port_pins_top.sv]
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
// Function
// RULE1: all eight motor port lines come up as inputs; lines shared with pulse outputs.
// RULE2: all four serial port lines come up as inputs; two shared with serial link.
// RULE3: all eight analog port lines come up as inputs; shared with converter.
// RULE4: timer line seven is input only; writes ignored, reads show the pin.
// RULE5: timer line six is general purpose only with capture irq and select clear.
// RULE6: sensitivity bit picks edge only or edge plus held active level.
// RULE7: polarity bit picks rising or falling edge as the trigger.
// RULE8: interrupt is serviced only after the current instruction completes.
// RULE9: all port and interrupt logic runs on the bus clock, oscillator over two.
// RULE10: reset pin low resets the block; internal resets drive the pin low.
// RULE11: interrupt pin is synchronised and edges found from consecutive samples.
module port_pins_top (
	input wire logic i_clock,
	input wire logic i_rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] i_motor_pin,
	output logic [7:0] o_motor_out,
	output logic [7:0] o_motor_oe,
	input wire logic [7:0] i_pulse_alt_en,
	input wire logic [7:0] i_pulse_alt_out,
	input wire logic [3:0] i_serial_pin,
	output logic [3:0] o_serial_out,
	output logic [3:0] o_serial_oe,
	input wire logic i_serial_tx_en,
	input wire logic i_serial_tx,
	input wire logic i_serial_rx_en,
	output logic o_serial_rx_pin,
	input wire logic [7:0] i_analog_pin,
	output logic [7:0] o_analog_out,
	output logic [7:0] o_analog_oe,
	input wire logic [7:0] i_analog_en,
	input wire logic [1:0] i_timer_pin,
	output logic o_timer_port_line6_out,
	output logic o_timer_port_line6_oe,
	input wire logic i_compare_output,
	output logic o_capture_input_one,
	output logic o_capture_input_two,
	input wire logic i_ext_int_pin,
	input wire logic i_instr_done,
	output logic o_ext_int_service,
	output logic o_irq,
	input wire logic i_reset_pin,
	input wire logic i_internal_reset_req,
	output logic o_reset_pin_out,
	output logic o_reset_pin_oe
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] motor_data;
		logic [7:0] motor_dir;
		logic [7:0] motor_out;
		logic [7:0] motor_oe;
		logic [3:0] serial_data;
		logic [3:0] serial_dir;
		logic [3:0] serial_out;
		logic [3:0] serial_oe;
		logic [7:0] analog_data;
		logic [7:0] analog_dir;
		logic [7:0] analog_out;
		logic [7:0] analog_oe;
		logic tline6_data;
		logic tline6_dir;
		logic tline6_out;
		logic tline6_oe;
		logic cap1_ie;
		logic cc_sel;
		logic sens;
		logic edge_rise;
		logic ext_mask;
		logic ext_req;
		logic ext_prev;
		logic line7_prev;
		logic [port_pins_pkg::INT_W-1:0] int_status;
		logic [port_pins_pkg::INT_W-1:0] int_mask;
		logic irq;
		logic service;
		logic sw_reset;
		logic serial_rx;
		logic cap1;
		logic cap2;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} state_s;

	state_s st_q;
	state_s st_d;

	logic [port_pins_pkg::SYNC_W-1:0] sync_level;
	logic [7:0] motor_lvl;
	logic [3:0] serial_lvl;
	logic [7:0] analog_lvl;
	logic [1:0] timer_lvl;
	logic ext_lvl;
	logic reset_pin_lvl;
	logic core_rst_b;

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	pin_sync #(
		.W(port_pins_pkg::SYNC_W),
		.INIT(port_pins_pkg::SYNC_INIT)
	) u_sync (
		.i_clock(i_clock),
		.i_rst_b(i_rst_b),
		.i_pin({i_reset_pin, i_ext_int_pin, i_timer_pin, i_analog_pin,
			i_serial_pin, i_motor_pin}), // [RULE11]
		.o_level(sync_level)
	);

	assign {reset_pin_lvl, ext_lvl, timer_lvl, analog_lvl, serial_lvl, motor_lvl} = sync_level;

	// a low reset pin resets everything here but the synchronisers and u_rst_drv,
	// so the pin can be watched again as soon as it is released
	assign core_rst_b = i_rst_b & reset_pin_lvl; // [RULE10]

	reset_pin_driver u_rst_drv (
		.i_clock(i_clock),
		.i_rst_b(i_rst_b),
		.i_request(st_q.sw_reset | i_internal_reset_req), // [RULE10]
		.o_pin_out(o_reset_pin_out),
		.o_pin_oe(o_reset_pin_oe)
	);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	logic setup;
	logic access;
	logic ext_active;
	logic ext_edge;
	logic ext_set;
	logic line7_edge;
	logic ext_ack;
	logic stat_clr;
	logic tline6_gpio;
	logic [31:0] rd;
	logic hit;
	logic [port_pins_pkg::INT_W-1:0] int_set;

	always_comb begin
		st_d = st_q;
		setup = psel & ~penable;
		access = psel & penable & st_q.pready;
		ext_ack = 1'b0;
		stat_clr = 1'b0;
		rd = port_pins_pkg::ZERO_WORD;
		hit = 1'b1;
		int_set = '0;

		// external interrupt detection from consecutive samples
		st_d.ext_prev = ext_lvl;
		ext_active = st_q.edge_rise ? ext_lvl : ~ext_lvl; // [RULE7]
		ext_edge = st_q.edge_rise ? (ext_lvl & ~st_q.ext_prev)
			: (~ext_lvl & st_q.ext_prev); // [RULE11] [RULE7]
		ext_set = ext_edge | (st_q.sens & ext_active); // [RULE6]
		st_d.line7_prev = timer_lvl[port_pins_pkg::TLINE7_BIT];
		line7_edge = timer_lvl[port_pins_pkg::TLINE7_BIT] ^ st_q.line7_prev;
		int_set[port_pins_pkg::INT_EXT_BIT] = ext_set;
		int_set[port_pins_pkg::INT_LINE7_BIT] = line7_edge;

		// ---------------- register read decode ----------------
		if (paddr == port_pins_pkg::OFF_MOTOR_DATA) begin
			rd[7:0] = (st_q.motor_dir & st_q.motor_data) | (~st_q.motor_dir & motor_lvl);
		end else if (paddr == port_pins_pkg::OFF_MOTOR_DIR) begin
			rd[7:0] = st_q.motor_dir;
		end else if (paddr == port_pins_pkg::OFF_SERIAL_DATA) begin
			rd[3:0] = (st_q.serial_dir & st_q.serial_data) | (~st_q.serial_dir & serial_lvl);
		end else if (paddr == port_pins_pkg::OFF_SERIAL_DIR) begin
			rd[3:0] = st_q.serial_dir;
		end else if (paddr == port_pins_pkg::OFF_ANALOG_DATA) begin
			rd[7:0] = (st_q.analog_dir & st_q.analog_data) | (~st_q.analog_dir & analog_lvl);
		end else if (paddr == port_pins_pkg::OFF_ANALOG_DIR) begin
			rd[7:0] = st_q.analog_dir;
		end else if (paddr == port_pins_pkg::OFF_TIMER_DATA) begin
			rd[port_pins_pkg::TLINE6_BIT] = st_q.tline6_dir ? st_q.tline6_data
				: timer_lvl[port_pins_pkg::TLINE6_BIT];
			rd[port_pins_pkg::TLINE7_BIT] = timer_lvl[port_pins_pkg::TLINE7_BIT]; // [RULE4]
		end else if (paddr == port_pins_pkg::OFF_TIMER_DIR) begin
			rd[port_pins_pkg::TLINE6_BIT] = st_q.tline6_dir;
		end else if (paddr == port_pins_pkg::OFF_TIMER_CTRL) begin
			rd[port_pins_pkg::TCR_CAP1_IE_BIT] = st_q.cap1_ie;
			rd[port_pins_pkg::TCR_CC_SEL_BIT] = st_q.cc_sel;
		end else if (paddr == port_pins_pkg::OFF_EXT_INT_CTRL) begin
			rd[port_pins_pkg::EXT_INT_STATUS_CONTROL_REG_SENS_BIT] = st_q.sens;
			rd[port_pins_pkg::EXT_INT_STATUS_CONTROL_REG_EDGE_BIT] = st_q.edge_rise;
			rd[port_pins_pkg::EXT_INT_STATUS_CONTROL_REG_MASK_BIT] = st_q.ext_mask;
			rd[port_pins_pkg::EXT_INT_STATUS_CONTROL_REG_REQ_BIT] = st_q.ext_req;
		end else if (paddr == port_pins_pkg::OFF_INT_STATUS) begin
			rd[port_pins_pkg::INT_W-1:0] = st_q.int_status;
		end else if (paddr == port_pins_pkg::OFF_INT_MASK) begin
			rd[port_pins_pkg::INT_W-1:0] = st_q.int_mask;
		end else if (paddr == port_pins_pkg::OFF_RESET_CTRL) begin
			rd[port_pins_pkg::RST_SW_BIT] = st_q.sw_reset;
		end else begin
			hit = 1'b0;
		end

		// read data is captured in setup so it can leave a flop in access
		st_d.pready = setup;
		if (setup) begin
			st_d.prdata = pwrite ? port_pins_pkg::ZERO_WORD : rd;
			st_d.pslverr = ~hit;
		end

		// ---------------- register write at access completion ----------------
		st_d.sw_reset = 1'b0;
		if (access && pwrite && hit) begin
			if (paddr == port_pins_pkg::OFF_MOTOR_DATA) begin
				st_d.motor_data = pwdata[7:0];
			end else if (paddr == port_pins_pkg::OFF_MOTOR_DIR) begin
				st_d.motor_dir = pwdata[7:0];
			end else if (paddr == port_pins_pkg::OFF_SERIAL_DATA) begin
				st_d.serial_data = pwdata[3:0];
			end else if (paddr == port_pins_pkg::OFF_SERIAL_DIR) begin
				st_d.serial_dir = pwdata[3:0];
			end else if (paddr == port_pins_pkg::OFF_ANALOG_DATA) begin
				st_d.analog_data = pwdata[7:0];
			end else if (paddr == port_pins_pkg::OFF_ANALOG_DIR) begin
				st_d.analog_dir = pwdata[7:0];
			end else if (paddr == port_pins_pkg::OFF_TIMER_DATA) begin
				// line seven has no latch; its bit is dropped
				st_d.tline6_data = pwdata[port_pins_pkg::TLINE6_BIT]; // [RULE4]
			end else if (paddr == port_pins_pkg::OFF_TIMER_DIR) begin
				st_d.tline6_dir = pwdata[port_pins_pkg::TLINE6_BIT];
			end else if (paddr == port_pins_pkg::OFF_TIMER_CTRL) begin
				st_d.cap1_ie = pwdata[port_pins_pkg::TCR_CAP1_IE_BIT];
				st_d.cc_sel = pwdata[port_pins_pkg::TCR_CC_SEL_BIT];
			end else if (paddr == port_pins_pkg::OFF_EXT_INT_CTRL) begin
				st_d.sens = pwdata[port_pins_pkg::EXT_INT_STATUS_CONTROL_REG_SENS_BIT]; // [RULE6]
				st_d.edge_rise = pwdata[port_pins_pkg::EXT_INT_STATUS_CONTROL_REG_EDGE_BIT]; // [RULE7]
				st_d.ext_mask = pwdata[port_pins_pkg::EXT_INT_STATUS_CONTROL_REG_MASK_BIT];
				ext_ack = pwdata[port_pins_pkg::EXT_INT_STATUS_CONTROL_REG_ACK_BIT];
			end else if (paddr == port_pins_pkg::OFF_INT_MASK) begin
				st_d.int_mask = pwdata[port_pins_pkg::INT_W-1:0];
			end else if (paddr == port_pins_pkg::OFF_RESET_CTRL) begin
				st_d.sw_reset = pwdata[port_pins_pkg::RST_SW_BIT]; // [RULE10]
			end
		end
		if (access && !pwrite && paddr == port_pins_pkg::OFF_INT_STATUS) begin
			stat_clr = 1'b1;
		end

		// new events win over an acknowledge or a clearing read
		st_d.ext_req = ext_set | (st_q.ext_req & ~ext_ack); // [RULE6]
		st_d.int_status = int_set | (st_q.int_status & {port_pins_pkg::INT_W{~stat_clr}});
		st_d.irq = |(st_q.int_status & st_q.int_mask);

		// the core raises i_instr_done only between instructions
		st_d.service = st_q.ext_req & ~st_q.ext_mask & i_instr_done; // [RULE8]

		// ---------------- pin drivers ----------------
		for (int k = 0; k < port_pins_pkg::MOTOR_W; k++) begin
			st_d.motor_oe[k] = st_q.motor_dir[k] | i_pulse_alt_en[k]; // [RULE1]
			st_d.motor_out[k] = i_pulse_alt_en[k] ? i_pulse_alt_out[k] : st_q.motor_data[k];
		end
		st_d.serial_oe = st_q.serial_dir; // [RULE2]
		st_d.serial_out = st_q.serial_data;
		if (i_serial_tx_en) begin
			st_d.serial_oe[port_pins_pkg::SERIAL_TX_BIT] = 1'b1;
			st_d.serial_out[port_pins_pkg::SERIAL_TX_BIT] = i_serial_tx;
		end
		if (i_serial_rx_en) begin
			st_d.serial_oe[port_pins_pkg::SERIAL_RX_BIT] = 1'b0;
		end
		st_d.serial_rx = serial_lvl[port_pins_pkg::SERIAL_RX_BIT];
		// a line handed to the converter is never driven
		st_d.analog_oe = st_q.analog_dir & ~i_analog_en; // [RULE3]
		st_d.analog_out = st_q.analog_data;

		tline6_gpio = ~st_q.cap1_ie & ~st_q.cc_sel; // [RULE5]
		if (st_q.cc_sel) begin
			st_d.tline6_oe = 1'b1;
			st_d.tline6_out = i_compare_output;
		end else if (tline6_gpio) begin
			st_d.tline6_oe = st_q.tline6_dir; // [RULE5]
			st_d.tline6_out = st_q.tline6_data;
		end else begin
			st_d.tline6_oe = 1'b0;
			st_d.tline6_out = 1'b0;
		end
		st_d.cap1 = timer_lvl[port_pins_pkg::TLINE6_BIT];
		st_d.cap2 = timer_lvl[port_pins_pkg::TLINE7_BIT];
	end

	// ------------------------------------------------------------
	// registers on the bus clock
	// ------------------------------------------------------------
	always_ff @(posedge i_clock) begin // [RULE9]
		if (!core_rst_b) begin
			st_q <= '0;
			st_q.motor_dir <= port_pins_pkg::DIR_RESET; // [RULE1]
			st_q.motor_data <= port_pins_pkg::DATA_RESET;
			st_q.serial_dir <= port_pins_pkg::DIR_RESET[3:0]; // [RULE2]
			st_q.analog_dir <= port_pins_pkg::DIR_RESET; // [RULE3]
			st_q.tline6_dir <= 1'b0;
			st_q.cap1_ie <= 1'b0; // [RULE5]
			st_q.cc_sel <= 1'b0; // [RULE5]
			st_q.ext_prev <= 1'b1;
			st_q.line7_prev <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign prdata = st_q.prdata;
	assign pready = st_q.pready;
	assign pslverr = st_q.pslverr;
	assign o_motor_out = st_q.motor_out;
	assign o_motor_oe = st_q.motor_oe;
	assign o_serial_out = st_q.serial_out;
	assign o_serial_oe = st_q.serial_oe;
	assign o_serial_rx_pin = st_q.serial_rx;
	assign o_analog_out = st_q.analog_out;
	assign o_analog_oe = st_q.analog_oe;
	assign o_timer_port_line6_out = st_q.tline6_out;
	assign o_timer_port_line6_oe = st_q.tline6_oe;
	assign o_capture_input_one = st_q.cap1;
	assign o_capture_input_two = st_q.cap2;
	assign o_ext_int_service = st_q.service;
	assign o_irq = st_q.irq;

endmodule

// [logic/reset_pin_driver.sv]
`timescale 1ns/1ps
module reset_pin_driver (
	input wire logic i_clock,
	input wire logic i_rst_b,
	input wire logic i_request,
	output logic o_pin_out,
	output logic o_pin_oe
);

	typedef struct packed {
		logic [port_pins_pkg::RESET_CNT_W-1:0] cnt;
		logic oe;
	} drv_s;

	drv_s st_q;
	drv_s st_d;

	// ------------------------------------------------------------
	// stretch an internal reset so the pin is seen low by the board
	// ------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		if (i_request) begin
			st_d.cnt = port_pins_pkg::RESET_CNT_W'(port_pins_pkg::RESET_DRIVE_CYCLES);
			st_d.oe = 1'b1; // [RULE10]
		end else if (st_q.cnt != '0) begin
			st_d.cnt = st_q.cnt - 1'b1;
			st_d.oe = (st_q.cnt != 1'b1);
		end else begin
			st_d.oe = 1'b0;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// pin only ever pulled low, like an open drain
	assign o_pin_out = 1'b0;
	assign o_pin_oe = st_q.oe;

endmodule
